// ===== core/rcg_pkg.sv
// Shared constants for the reference clock generator control block
package rcg_pkg;
    localparam int RCG_ADDR_W = 4;
    localparam logic [RCG_ADDR_W-1:0] RCG_CTRL_OFFSET = 4'h0;
    localparam int RCG_DIV_W = 15;
    localparam int RCG_SEL_W = 4;
    localparam int RCG_DIV_LSB = 16;
    localparam int RCG_ON_BIT = 15;
    localparam int RCG_STOP_IN_IDLE_BIT = 13;
    localparam int RCG_OE_BIT = 12;
    localparam int RCG_RUN_IN_SLEEP_BIT = 11;
    localparam int RCG_DIVSW_BIT = 9;
    localparam int RCG_ACTIVE_BIT = 8;
    localparam int RCG_SEL_LSB = 0;
    localparam logic [31:0] RCG_CTRL_RESET = 32'h0000_0000;
    localparam logic [RCG_SEL_W-1:0] RCG_SEL_NO_SLEEP0 = 4'h0;
    localparam logic [RCG_SEL_W-1:0] RCG_SEL_NO_SLEEP1 = 4'h1;
    localparam int RCG_SYNC_STAGES = 3;
    typedef enum logic [1:0] {
        RCG_SW_IDLE = 2'b00,
        RCG_SW_WAIT = 2'b01,
        RCG_SW_DONE = 2'b10
    } rcg_switch_t;
endpackage : rcg_pkg

// ===== core/rcg_sync.sv
// Three-stage input synchroniser, level accepted once stages two and three agree
`timescale 1ns/10ps
module rcg_sync #(
    parameter int WIDTH = 16
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // Asynchronous inputs and filtered levels
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] level_out
);
    import rcg_pkg::*;
    logic [WIDTH-1:0] s1_reg;
    logic [WIDTH-1:0] s2_reg;
    logic [WIDTH-1:0] s3_reg;
    logic [WIDTH-1:0] level_next;
    wire [WIDTH-1:0] agree = ~(s2_reg ^ s3_reg);

    initial begin
        if (WIDTH < 1) $error("rcg_sync: WIDTH must be at least 1");
    end

    assign level_next = (agree & s3_reg) | (~agree & level_out);

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
            level_out <= '0;
        end else begin
            s1_reg <= async_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            level_out <= level_next;
        end
    end
endmodule : rcg_sync

// ===== core/rcg_divider.sv
// Divides the selected source level by a programmable ratio
`timescale 1ns/10ps
module rcg_divider #(
    parameter int DIV_W = 15
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // Source level and control
    input wire logic src_level,
    input wire logic run,
    input wire logic [DIV_W-1:0] ratio,
    // Divided level and end-of-period pulse
    output logic div_out,
    output logic period_end
);
    import rcg_pkg::*;
    logic src_prev_reg;
    logic [DIV_W-1:0] cnt_reg;
    logic [DIV_W-1:0] cnt_next;
    logic out_next;
    wire src_rise = src_level & ~src_prev_reg;
    wire src_chg = src_level ^ src_prev_reg;
    wire bypass = (ratio == '0);
    wire wrap = src_rise & (cnt_reg >= ratio - DIV_W'(1));

    initial begin
        if (DIV_W < 1) $error("rcg_divider: DIV_W must be at least 1");
    end

    // Ratio zero passes the source through, else toggles every ratio rising edges
    always_comb begin
        cnt_next = cnt_reg;
        out_next = div_out;
        if (!run) begin
            cnt_next = '0;
            out_next = 1'b0;
        end else if (bypass) begin
            cnt_next = '0;
            out_next = src_level;
        end else if (wrap) begin
            cnt_next = '0;
            out_next = ~div_out;
        end else if (src_rise) begin
            cnt_next = cnt_reg + DIV_W'(1);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            src_prev_reg <= 1'b0;
            cnt_reg <= '0;
            div_out <= 1'b0;
            period_end <= 1'b0;
        end else begin
            src_prev_reg <= src_level;
            cnt_reg <= cnt_next;
            div_out <= out_next;
            period_end <= run & (bypass ? (src_chg & ~src_level) : (wrap & div_out));
        end
    end
endmodule : rcg_divider

// ===== core/rcg_ctrl.sv
// Reference clock generator control register, APB slave and output gating
//
// Contract
// - Bits 30..16 hold a 15-bit ratio that divides the selected source.
// - Bit 15 enables the whole generator; zero keeps it disabled.
// - Bit 13 set stops the generator while the chip is idle, clear keeps it running.
// - Bit 12 set drives the divided clock on the output pin, clear keeps the pin quiet.
// - Bit 11 set keeps the output running in sleep, clear stops it in sleep.
// - The run-in-sleep bit is ignored when the source select is 0000 or 0001.
// - Bit 9 reads one while a divider switch is pending and hardware clears it when done.
// - Bit 8 is read-only and shows whether a clock request is active, set and cleared by hardware.
// - While enabled, new source and ratio values wait until the switch bit is set.
// - Bits 31, 14, 10 and 7..4 read zero and ignore writes.
//
// Design decisions made here: the register offsets and register access over APB.
`timescale 1ns/10ps
module rcg_ctrl #(
    parameter int NUM_SRC = 16,
    parameter int DIV_W = 15
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [rcg_pkg::RCG_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Clock sources from pins and chip power state
    input wire logic [NUM_SRC-1:0] src_clk_in,
    input wire logic idle_mode,
    input wire logic sleep_mode,
    // Generated clock
    output logic ref_clk,
    output logic ref_clock_out_pin
);
    import rcg_pkg::*;

    logic [DIV_W-1:0] ratio_shadow_reg;
    logic [RCG_SEL_W-1:0] sel_shadow_reg;
    logic [DIV_W-1:0] ratio_live_reg;
    logic [RCG_SEL_W-1:0] sel_live_reg;
    logic on_reg;
    logic stop_in_idle_reg;
    logic oe_reg;
    logic run_in_sleep_reg;
    logic active_reg;
    rcg_switch_t sw_reg;
    rcg_switch_t sw_next;
    logic [DIV_W-1:0] ratio_shadow_next;
    logic [RCG_SEL_W-1:0] sel_shadow_next;
    logic [DIV_W-1:0] ratio_live_next;
    logic [RCG_SEL_W-1:0] sel_live_next;
    logic [NUM_SRC-1:0] src_level;
    logic div_out;
    logic period_end;

    initial begin
        if (NUM_SRC < 1 || NUM_SRC > (1 << RCG_SEL_W))
            $error("rcg_ctrl: NUM_SRC must be 1..16");
        if (DIV_W != RCG_DIV_W)
            $error("rcg_ctrl: DIV_W must match the register field");
    end

    // Bus decode
    wire setup = psel & ~penable;
    wire hit = (paddr == RCG_CTRL_OFFSET);
    wire access = psel & penable & pready;
    wire wr_ctrl = access & pwrite & hit;

    // Write data fields
    wire [DIV_W-1:0] wr_ratio = pwdata[RCG_DIV_LSB +: DIV_W];
    wire [RCG_SEL_W-1:0] wr_sel = pwdata[RCG_SEL_LSB +: RCG_SEL_W];
    wire wr_on = pwdata[RCG_ON_BIT];
    wire wr_divsw = wr_ctrl & pwdata[RCG_DIVSW_BIT];

    // Sleep gating per source
    wire sleep_ignored = (sel_live_reg == RCG_SEL_NO_SLEEP0)
        | (sel_live_reg == RCG_SEL_NO_SLEEP1);
    wire sleep_keep = run_in_sleep_reg & ~sleep_ignored;
    wire idle_stop = idle_mode & stop_in_idle_reg;
    wire sleep_stop = sleep_mode & ~sleep_keep;
    wire gen_run = on_reg & ~idle_stop & ~sleep_stop;

    // Source mux
    wire src_sel_level = (int'(sel_live_reg) < NUM_SRC)
        ? src_level[sel_live_reg] : 1'b0;

    // Switch completes at a period boundary, or at once if stopped
    wire sw_pending = (sw_reg == RCG_SW_WAIT);
    wire sw_apply = sw_pending & (period_end | ~gen_run);
    wire divsw_bit = sw_pending;

    // Read word, unimplemented bits zero
    wire [31:0] rd_word = {
        1'b0,
        ratio_shadow_reg,
        on_reg,
        1'b0,
        stop_in_idle_reg,
        oe_reg,
        run_in_sleep_reg,
        1'b0,
        divsw_bit,
        active_reg,
        4'h0,
        sel_shadow_reg
    };

    // Shadow fields always take written values
    assign ratio_shadow_next = wr_ctrl ? wr_ratio : ratio_shadow_reg;
    assign sel_shadow_next = wr_ctrl ? wr_sel : sel_shadow_reg;

    // Live fields follow the shadow while off, else wait for the switch
    always_comb begin
        ratio_live_next = ratio_live_reg;
        sel_live_next = sel_live_reg;
        if (!on_reg) begin
            ratio_live_next = ratio_shadow_next;
            sel_live_next = sel_shadow_next;
        end else if (sw_apply) begin
            ratio_live_next = ratio_shadow_reg;
            sel_live_next = sel_shadow_reg;
        end
    end

    // Switch state, a new request while pending is ignored and completion wins
    always_comb begin
        case (sw_reg)
            RCG_SW_IDLE: begin
                sw_next = (wr_divsw && on_reg) ? RCG_SW_WAIT : RCG_SW_IDLE;
            end
            RCG_SW_WAIT: begin
                sw_next = sw_apply ? RCG_SW_DONE : RCG_SW_WAIT;
            end
            RCG_SW_DONE: begin
                sw_next = wr_divsw ? RCG_SW_WAIT : RCG_SW_IDLE;
            end
            default: begin
                sw_next = RCG_SW_IDLE;
            end
        endcase
        if (wr_divsw && on_reg && sw_reg != RCG_SW_WAIT)
            sw_next = RCG_SW_WAIT;
        if (!on_reg && !(wr_ctrl && wr_on))
            sw_next = RCG_SW_IDLE;
    end

    rcg_sync #(
        .WIDTH(NUM_SRC)
    ) u_sync (
        .sys_clk(sys_clk),
        .srst(srst),
        .async_in(src_clk_in),
        .level_out(src_level)
    );

    rcg_divider #(
        .DIV_W(DIV_W)
    ) u_div (
        .sys_clk(sys_clk),
        .srst(srst),
        .src_level(src_sel_level),
        .run(gen_run),
        .ratio(ratio_live_reg),
        .div_out(div_out),
        .period_end(period_end)
    );

    // APB answer: one access cycle, error on unmapped address
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= setup;
            pslverr <= setup & ~hit;
            prdata <= (setup && hit && !pwrite) ? rd_word : 32'h0000_0000;
        end
    end

    // Control fields
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            ratio_shadow_reg <= RCG_CTRL_RESET[RCG_DIV_LSB +: DIV_W];
            sel_shadow_reg <= RCG_CTRL_RESET[RCG_SEL_LSB +: RCG_SEL_W];
            ratio_live_reg <= RCG_CTRL_RESET[RCG_DIV_LSB +: DIV_W];
            sel_live_reg <= RCG_CTRL_RESET[RCG_SEL_LSB +: RCG_SEL_W];
            on_reg <= RCG_CTRL_RESET[RCG_ON_BIT];
            stop_in_idle_reg <= RCG_CTRL_RESET[RCG_STOP_IN_IDLE_BIT];
            oe_reg <= RCG_CTRL_RESET[RCG_OE_BIT];
            run_in_sleep_reg <= RCG_CTRL_RESET[RCG_RUN_IN_SLEEP_BIT];
            sw_reg <= RCG_SW_IDLE;
        end else begin
            ratio_shadow_reg <= ratio_shadow_next;
            sel_shadow_reg <= sel_shadow_next;
            ratio_live_reg <= ratio_live_next;
            sel_live_reg <= sel_live_next;
            sw_reg <= sw_next;
            if (wr_ctrl) begin
                on_reg <= wr_on;
                stop_in_idle_reg <= pwdata[RCG_STOP_IN_IDLE_BIT];
                oe_reg <= pwdata[RCG_OE_BIT];
                run_in_sleep_reg <= pwdata[RCG_RUN_IN_SLEEP_BIT];
            end
        end
    end

    // Status and clock outputs
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            active_reg <= RCG_CTRL_RESET[RCG_ACTIVE_BIT];
            ref_clk <= 1'b0;
            ref_clock_out_pin <= 1'b0;
        end else begin
            active_reg <= gen_run;
            ref_clk <= div_out & gen_run;
            ref_clock_out_pin <= div_out & gen_run & oe_reg;
        end
    end
endmodule : rcg_ctrl

// ===== testbench/rcg_ctrl_properties.sv
// Concurrent checks on the control block ports
`timescale 1ns/10ps
module rcg_ctrl_properties (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // Bus and power state
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [rcg_pkg::RCG_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic idle_mode,
    input wire logic sleep_mode,
    // Generated clock
    input wire logic ref_clk,
    input wire logic ref_clock_out_pin
);
    import rcg_pkg::*;
    logic [31:0] ctl_reg;
    logic [2:0] off_reg;
    wire rd_ok = pready && !pwrite && paddr == RCG_CTRL_OFFSET;
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            ctl_reg <= '0;
        end else if (psel && penable && pwrite && pready && paddr == RCG_CTRL_OFFSET) begin
            ctl_reg <= pwdata;
        end
    end
    // Cycles spent with the generator off, saturating
    always_ff @(posedge sys_clk) begin
        if (srst || ctl_reg[RCG_ON_BIT]) begin
            off_reg <= '0;
        end else if (off_reg != 3'h7) begin
            off_reg <= off_reg + 3'h1;
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (srst);
    reserved_zero_a: assert property (rd_ok |-> (prdata & 32'h8000_44F0) == '0)
        else $error("reserved bits read nonzero");
    field_read_a: assert property (rd_ok |-> (prdata & 32'h7FFF_B80F) == (ctl_reg & 32'h7FFF_B80F))
        else $error("control fields read wrong");
    active_off_a: assert property (rd_ok && off_reg == 3'h7 |-> !prdata[RCG_ACTIVE_BIT])
        else $error("active set while off");
    switch_off_a: assert property (rd_ok && off_reg == 3'h7 |-> !prdata[RCG_DIVSW_BIT])
        else $error("switch pending while off");
    gen_off_a: assert property (off_reg == 3'h7 |-> !ref_clk)
        else $error("clock runs while off");
    pin_quiet_a: assert property (!ctl_reg[RCG_OE_BIT] [*3] |-> !ref_clock_out_pin)
        else $error("pin driven with output off");
    idle_stop_a: assert property ((idle_mode && ctl_reg[RCG_STOP_IN_IDLE_BIT]) [*4] |-> !ref_clk)
        else $error("clock runs in idle");
    sleep_stop_a: assert property ((sleep_mode && !ctl_reg[RCG_RUN_IN_SLEEP_BIT]) [*4] |-> !ref_clk)
        else $error("clock runs in sleep");
    reset_clear_a: assert property ($fell(srst) |-> !ref_clk && !ref_clock_out_pin && !pready)
        else $error("outputs not clear after reset");
    cover property ($rose(ref_clock_out_pin));
    cover property (rd_ok && prdata[RCG_ACTIVE_BIT]);
    cover property (idle_mode && ctl_reg[RCG_STOP_IN_IDLE_BIT]);
endmodule : rcg_ctrl_properties

bind rcg_ctrl rcg_ctrl_properties u_props (.sys_clk(sys_clk), .srst(srst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .idle_mode(idle_mode), .sleep_mode(sleep_mode), .ref_clk(ref_clk),
    .ref_clock_out_pin(ref_clock_out_pin));

// ===== testbench/test_reference_clock_generator_control.sv
// Self-checking bench for the reference clock control block
`timescale 1ns/10ps
module test_reference_clock_generator_control;
    import rcg_pkg::*;
    logic sys_clk, srst, psel, penable, pwrite, idle_mode, sleep_mode, err;
    logic pready, pslverr, ref_clk, ref_clock_out_pin;
    logic [RCG_ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, rd, d;
    logic [15:0] src_clk_in;
    logic [2:0] ph = 3'h0;
    int error_cnt, n_checks, cnt;
    rcg_ctrl DUT (.sys_clk(sys_clk), .srst(srst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .src_clk_in(src_clk_in), .idle_mode(idle_mode),
        .sleep_mode(sleep_mode), .ref_clk(ref_clk), .ref_clock_out_pin(ref_clock_out_pin));
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    // Sources toggle every 8 cycles
    always @(posedge sys_clk) begin
        ph <= ph + 3'h1;
        if (ph == 3'h7) src_clk_in <= ~src_clk_in;
    end
    task automatic end_of_test;
        $display("Checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_of_test
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [3:0] a, input logic [31:0] v);
        int n;
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= v;
        @(posedge sys_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // Rises over 384 cycles; ratio 0 means stopped
    task automatic rise_chk(input logic pin, input int ratio);
        int e;
        logic prev, now;
        e = ratio == 0 ? 0 : 384 / (32 * ratio);
        repeat (30) @(posedge sys_clk);
        cnt = 0;
        prev = 1'b0;
        repeat (384) begin
            @(posedge sys_clk);
            now = pin ? ref_clock_out_pin : ref_clk;
            if (now === 1'b1 && !prev) cnt++;
            prev = now;
        end
        chk("rise count", e, cnt >= e - 1 && cnt <= e + (e != 0) ? e : cnt);
    endtask : rise_chk
    initial begin
        srst = 1'b1;
        {psel, penable, pwrite, idle_mode, sleep_mode} = '0;
        paddr = '0;
        pwdata = '0;
        src_clk_in = '0;
        error_cnt = 0;
        n_checks = 0;
        void'($urandom(32'h5F8FD183));
        repeat (20) @(posedge sys_clk);
        srst <= 1'b0;
        apb(0, RCG_CTRL_OFFSET, 0);
        chk("reset value", RCG_CTRL_RESET, rd);
        for (int i = 0; i < 20; i++) begin
            d = i == 0 ? 32'hFFFF_7FFF : $urandom() & 32'hFFFF_7FFF;
            apb(1, RCG_CTRL_OFFSET, d);
            apb(0, RCG_CTRL_OFFSET, 0);
            chk("readback", d & 32'h7FFF_B80F, rd);
        end
        apb(1, 4'h4, 32'hFFFF_FFFF);
        chk("slverr", 1, err);
        apb(0, RCG_CTRL_OFFSET, 0);
        chk("after unmapped", d & 32'h7FFF_B80F, rd);
        apb(1, RCG_CTRL_OFFSET, 32'h0001_1002);
        apb(1, RCG_CTRL_OFFSET, 32'h0001_9002);
        rise_chk(1, 1);
        apb(0, RCG_CTRL_OFFSET, 0);
        chk("active", 32'h0001_9102, rd);
        apb(1, RCG_CTRL_OFFSET, 32'h0001_8002);
        rise_chk(0, 1);
        rise_chk(1, 0);
        apb(1, RCG_CTRL_OFFSET, 32'h0003_9002);
        rise_chk(1, 1);
        apb(1, RCG_CTRL_OFFSET, 32'h0003_9202);
        // A write returns zero read data, so poll the status by reading first
        apb(0, RCG_CTRL_OFFSET, 0);
        for (int i = 0; i < 40 && rd[RCG_DIVSW_BIT] !== 1'b0; i++) apb(0, RCG_CTRL_OFFSET, 0);
        chk("switch done", 32'h0003_9102, rd);
        rise_chk(1, 3);
        apb(1, RCG_CTRL_OFFSET, 32'h0003_B002);
        idle_mode <= 1'b1;
        rise_chk(1, 0);
        apb(1, RCG_CTRL_OFFSET, 32'h0003_9002);
        rise_chk(1, 3);
        idle_mode <= 1'b0;
        sleep_mode <= 1'b1;
        rise_chk(1, 0);
        apb(1, RCG_CTRL_OFFSET, 32'h0003_9802);
        rise_chk(1, 3);
        apb(1, RCG_CTRL_OFFSET, 32'h0003_1800);
        apb(1, RCG_CTRL_OFFSET, 32'h0003_9800);
        rise_chk(1, 0);
        sleep_mode <= 1'b0;
        rise_chk(1, 3);
        end_of_test();
    end
    initial begin
        repeat (20000) @(posedge sys_clk);
        error_cnt++;
        end_of_test();
    end
endmodule : test_reference_clock_generator_control
